// ==== hw/lsq_pkg.sv ====
// Package with constants and types for the loop sequencer.
// Functional notes
// R01: Do-command dispatches its command every time.
// R02: Repeat body for count or until exit.
// R03: Count zero repeats until exit fires.
// R04: Delay counts in whole execution intervals.
// R05: Delay zero runs all passes immediately.
// R06: Delay N: one pass every Nth tick.
// R07: Delayed loop resumes at loop, skipping table.
// R08: Counted delayed loop: delay after every pass.
// R09: Delayed loop inhibits restart, hides overrun.
// R10: Output flag not auto-cleared in delayed loop.
// R11: Table two blocked during table one delay.
// R12: Table one waits while table two outputs.
// R13: Indexed location adds loop index counter.
// R14: Averages share one count and total.
// R15: Intermediate storage zeroed at each output.
// R16: Index comes from innermost enclosing loop.
// R17: Loops and if blocks nest nine deep.
// R18: If block with else counts two levels.
// R19: Loop takes delay then iteration count.
// R20: End closes innermost block, loops back.
// R21: Fresh loop entry zeroes its counters.
package lsq_pkg;

   // ----------------------------------------
   // Sizes and limits
   // ----------------------------------------
   localparam int LSQ_NEST_MAX = 9;
   localparam int LSQ_STK = 9;
   localparam int LSQ_SLOTS = 16;

   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] LSQ_CMD_FLAG0_HI = 8'h0A;
   localparam logic [7:0] LSQ_CMD_FLAG0_LO = 8'h14;
   localparam logic [7:0] LSQ_CMD_THEN = 8'h1E;
   localparam logic [7:0] LSQ_CMD_EXIT_T = 8'h1F;
   localparam logic [7:0] LSQ_CMD_EXIT_F = 8'h20;

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   localparam logic [1:0] LSQ_REG_STATUS = 2'h0;
   localparam logic [1:0] LSQ_REG_INDEX = 2'h1;
   localparam logic [1:0] LSQ_REG_CTRL = 2'h2;
   localparam int LSQ_CTRL_T2EN_BIT = 0;
   localparam int LSQ_CTRL_CLRERR_BIT = 1;
   localparam logic LSQ_CTRL_T2EN_RST = 1'b1;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      K_OTHER = 3'b000, K_DO = 3'b001, K_LOOP = 3'b010, K_CMD = 3'b011,
      K_ELSE = 3'b100, K_END = 3'b101, K_AVG = 3'b110, K_OPEN = 3'b111
   } lsq_kind_t;

   typedef enum logic [1:0] {
      A_NEXT = 2'b00, A_JUMP = 2'b01, A_WAIT = 2'b10, A_SKIP = 2'b11
   } lsq_act_kind_t;

   typedef enum logic [1:0] {
      E_LOOP = 2'b00, E_IF = 2'b01, E_IFELSE = 2'b10, E_OTHER = 2'b11
   } lsq_ent_t;

   typedef struct packed {
      logic valid;
      lsq_kind_t kind;
      logic [11:0] pc;
      logic [15:0] p1;
      logic [15:0] p2;
      logic [11:0] loc;
      logic indexed;
      logic [3:0] slot;
      logic [31:0] sample;
      logic cond_true;
   } lsq_instr_t;

   typedef struct packed {
      logic valid;
      lsq_act_kind_t kind;
      logic [11:0] pc;
   } lsq_act_t;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
   } lsq_cmd_t;

   typedef struct packed {
      logic valid;
      logic [15:0] count;
      logic [31:0] total;
   } lsq_avg_t;

endpackage

// ==== hw/lsq_top.sv ====
// Loop sequencer of the program interpreter: loops, nesting, delays, indexing.
//
// Design decisions made here: the plain strobed port and the address map.
module lsq_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Instruction stream
   input wire lsq_pkg::lsq_instr_t instr,
   // Scheduler
   input wire logic exec_tick,
   input wire logic table_start,
   input wire logic [1:0] cur_table,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Flow control and dispatch
   output lsq_pkg::lsq_act_t act,
   output lsq_pkg::lsq_cmd_t cmd,
   output logic [11:0] loc_eff,
   output lsq_pkg::lsq_avg_t avg_out,
   // Scheduling status
   output logic out_flag,
   output logic restart_inhibit,
   output logic overrun_hide,
   output logic table2_block,
   output logic table1_preempt_ok,
   output logic nest_err
);
   import lsq_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   lsq_ent_t kind_s [LSQ_STK];
   logic [11:0] head_s [LSQ_STK];
   logic [15:0] dly_s [LSQ_STK];
   logic [15:0] cnt_s [LSQ_STK];
   logic [15:0] iter_s [LSQ_STK];
   logic [15:0] idx_s [LSQ_STK];
   logic [15:0] acc_c [LSQ_SLOTS];
   logic [31:0] acc_t [LSQ_SLOTS];
   logic [3:0] sp_r;
   logic [3:0] level_r;
   logic wait_r;
   logic wait_more_r;
   logic [15:0] dly_cnt_r;
   logic [11:0] end_pc_r;
   logic skip_r;
   logic [3:0] skip_cnt_r;
   logic t2_en_r;
   logic [3:0] lp;
   logic has_lp;
   logic dly_any;

   // ----------------------------------------
   // Stack scan
   // ----------------------------------------
   // The innermost loop is the highest loop entry; if blocks above it
   // do not own an index counter.
   always_comb begin
      lp = 4'h0;
      has_lp = 1'b0;
      dly_any = 1'b0;
      for (int i = 0; i < LSQ_STK; i++) begin
         if (4'(i) < sp_r && kind_s[i] == E_LOOP) begin
            lp = 4'(i); // [R16]
            has_lp = 1'b1;
            if (dly_s[i] != 16'h0000) begin
               dly_any = 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // An empty stack reads entry zero, so no out-of-range index turns the outputs unknown.
   wire not_empty = sp_r != 4'h0;
   wire [3:0] top = not_empty ? sp_r - 4'h1 : 4'h0;
   wire lsq_ent_t top_kind = kind_s[top];
   wire top_loop = not_empty && top_kind == E_LOOP;
   wire live = instr.valid && !wait_r;
   wire run = live && !skip_r;
   wire k_do = instr.kind == K_DO;
   wire k_cmd = instr.kind == K_CMD;
   wire k_loop = instr.kind == K_LOOP;
   wire k_open = instr.kind == K_OPEN;
   wire [7:0] code = instr.p1[7:0];
   wire truth = k_do || instr.cond_true; // [R01]
   wire is_cmd = run && (k_do || k_cmd);
   wire exit_t = code == LSQ_CMD_EXIT_T && truth;
   wire exit_f = code == LSQ_CMD_EXIT_F && !truth;
   wire is_exit = is_cmd && has_lp && (exit_t || exit_f); // [R02] [R03]
   wire exit_code = code == LSQ_CMD_EXIT_T || code == LSQ_CMD_EXIT_F;
   wire is_then = (k_do || k_cmd) && code == LSQ_CMD_THEN;
   wire disp = is_cmd && truth && !exit_code && code != LSQ_CMD_THEN; // [R01]
   wire open_any = live && (k_loop || k_open || is_then);
   wire [1:0] new_w = k_open ? 2'h0 : 2'h1;
   wire [4:0] lvl_add = {1'b0, level_r} + {3'b000, new_w};
   wire push_ok = lvl_add <= 5'(LSQ_NEST_MAX) && sp_r < 4'(LSQ_STK);
   wire do_push = run && open_any && push_ok; // [R17]
   wire push_err = run && open_any && !push_ok;
   wire [4:0] lvl_else = {1'b0, level_r} + 5'h01;
   wire else_top = run && instr.kind == K_ELSE && not_empty && top_kind == E_IF;
   wire else_ok = else_top && lvl_else <= 5'(LSQ_NEST_MAX); // [R18]
   wire else_err = else_top && !else_ok;
   wire is_end = live && instr.kind == K_END;
   wire end_inner = is_end && skip_r && skip_cnt_r != 4'h0;
   wire end_pop = is_end && !end_inner && not_empty;
   wire loop_end = end_pop && top_loop && !skip_r;
   wire [15:0] iter_n = iter_s[top] + 16'h0001;
   wire more = cnt_s[top] == 16'h0000 || iter_n < cnt_s[top]; // [R02] [R03]
   wire loop_jump = loop_end && dly_s[top] == 16'h0000 && more; // [R05]
   wire loop_wait = loop_end && dly_s[top] != 16'h0000; // [R08]
   wire pop = end_pop && !loop_jump && !loop_wait; // [R20]
   wire [15:0] dly_n = dly_cnt_r + 16'h0001;
   wire dly_done = wait_r && exec_tick && dly_n == dly_s[top]; // [R04] [R06]
   wire wait_pop = dly_done && !wait_more_r;
   wire pop_any = pop || wait_pop;
   wire skip_done = pop && skip_r && top_loop;
   wire [3:0] top_w = top_kind == E_IFELSE ? 4'h2 : (top_kind == E_OTHER ? 4'h0 : 4'h1);
   wire avg_hit = run && instr.kind == K_AVG;
   wire [15:0] avg_c = acc_c[instr.slot] + 16'h0001;
   wire [31:0] avg_t = acc_t[instr.slot] + instr.sample; // [R14]
   wire [11:0] idx_add = (instr.indexed && has_lp) ? idx_s[lp][11:0] : 12'h000;
   wire lsq_ent_t push_kind = k_loop ? E_LOOP : (k_open ? E_OTHER : E_IF);
   wire flag_set = disp && code == LSQ_CMD_FLAG0_HI;
   wire flag_clr = disp && code == LSQ_CMD_FLAG0_LO;
   wire auto_clr = table_start && !dly_any; // [R10]
   wire wr_ctrl = reg_wr && reg_addr == LSQ_REG_CTRL;
   wire clr_err = wr_ctrl && reg_wdata[LSQ_CTRL_CLRERR_BIT];
   wire [15:0] status_w = {8'h00, nest_err, dly_any, out_flag, wait_r, level_r};
   wire [15:0] ctrl_w = {15'h0000, t2_en_r};
   wire [15:0] rd_mux = reg_addr == LSQ_REG_STATUS ? status_w :
                        reg_addr == LSQ_REG_INDEX ? idx_s[lp] & {16{has_lp}} :
                        reg_addr == LSQ_REG_CTRL ? ctrl_w : 16'h0000;
   wire [11:0] resume_pc = wait_more_r ? head_s[top] : end_pc_r + 12'h001;
   wire lsq_act_kind_t act_kind = dly_done ? A_JUMP : loop_jump ? A_JUMP :
                                  loop_wait ? A_WAIT :
                                  (skip_r && !skip_done) ? A_SKIP : A_NEXT;
   wire [11:0] act_pc = dly_done ? resume_pc : head_s[top];

   // ----------------------------------------
   // Loop stack
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < LSQ_STK; i++) begin
            kind_s[i] <= E_OTHER;
            head_s[i] <= 12'h000;
            dly_s[i] <= 16'h0000;
            cnt_s[i] <= 16'h0000;
            iter_s[i] <= 16'h0000;
            idx_s[i] <= 16'h0000;
         end
      end else begin
         if (do_push) begin
            kind_s[sp_r] <= push_kind;
            head_s[sp_r] <= instr.pc + 12'h001;
            dly_s[sp_r] <= instr.p1; // [R19]
            cnt_s[sp_r] <= instr.p2;
            iter_s[sp_r] <= 16'h0000; // [R21]
            idx_s[sp_r] <= 16'h0000;
         end
         if (else_ok) begin
            kind_s[top] <= E_IFELSE; // [R18]
         end
         if (loop_jump || loop_wait) begin
            iter_s[top] <= iter_n;
            idx_s[top] <= idx_s[top] + 16'h0001; // [R13]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_r <= 4'h0;
         level_r <= 4'h0;
      end else if (do_push) begin
         sp_r <= sp_r + 4'h1;
         level_r <= lvl_add[3:0]; // [R17]
      end else if (else_ok) begin
         level_r <= lvl_else[3:0];
      end else if (pop_any) begin
         sp_r <= top;
         level_r <= level_r - top_w; // [R20]
      end
   end

   // ----------------------------------------
   // Delay wait and exit skip
   // ----------------------------------------
   // While waiting the table is parked on the loop; the next pass starts
   // at the loop head, never at the table's first instruction.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 1'b0;
         wait_more_r <= 1'b0;
         dly_cnt_r <= 16'h0000;
         end_pc_r <= 12'h000;
      end else if (loop_wait) begin
         wait_r <= 1'b1; // [R07]
         wait_more_r <= more;
         dly_cnt_r <= 16'h0000;
         end_pc_r <= instr.pc;
      end else if (wait_r && exec_tick) begin
         dly_cnt_r <= dly_n; // [R04]
         wait_r <= !dly_done;
      end
   end

   // Skipped instructions still stream past so nested ends can be matched.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_r <= 1'b0;
         skip_cnt_r <= 4'h0;
      end else if (is_exit) begin
         skip_r <= 1'b1; // [R02]
         skip_cnt_r <= 4'h0;
      end else if (skip_r && open_any) begin
         skip_cnt_r <= skip_cnt_r + 4'h1;
      end else if (end_inner) begin
         skip_cnt_r <= skip_cnt_r - 4'h1;
      end else if (skip_done) begin
         skip_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Intermediate storage for averages
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < LSQ_SLOTS; i++) begin
            acc_c[i] <= 16'h0000;
            acc_t[i] <= 32'h0000_0000;
         end
      end else if (avg_hit) begin
         acc_c[instr.slot] <= out_flag ? 16'h0000 : avg_c; // [R15]
         acc_t[instr.slot] <= out_flag ? 32'h0000_0000 : avg_t; // [R14]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avg_out <= '0;
      end else begin
         avg_out.valid <= avg_hit && out_flag;
         avg_out.count <= avg_c;
         avg_out.total <= avg_t;
      end
   end

   // ----------------------------------------
   // Dispatch, flow actions and flags
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act <= '0;
         cmd <= '0;
         loc_eff <= 12'h000;
      end else begin
         act.valid <= live || dly_done;
         act.kind <= act_kind;
         act.pc <= act_pc;
         cmd.valid <= disp; // [R01]
         cmd.code <= code;
         loc_eff <= instr.loc + idx_add; // [R13] [R16]
      end
   end

   // A set in the same cycle as an automatic clear wins.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_flag <= 1'b0;
      end else if (flag_set) begin
         out_flag <= 1'b1;
      end else if (flag_clr || auto_clr) begin
         out_flag <= 1'b0; // [R10]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         restart_inhibit <= 1'b0;
         overrun_hide <= 1'b0;
         table2_block <= 1'b0;
         table1_preempt_ok <= 1'b1;
      end else begin
         restart_inhibit <= dly_any; // [R09]
         overrun_hide <= dly_any;
         table2_block <= (dly_any && cur_table == 2'h1) || !t2_en_r; // [R11]
         table1_preempt_ok <= !(cur_table == 2'h2 && out_flag); // [R12]
      end
   end

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         t2_en_r <= LSQ_CTRL_T2EN_RST;
         nest_err <= 1'b0;
         reg_rdata <= 16'h0000;
      end else begin
         if (wr_ctrl) begin
            t2_en_r <= reg_wdata[LSQ_CTRL_T2EN_BIT];
         end
         nest_err <= push_err || else_err || (nest_err && !clr_err); // [R17]
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   do_dispatch_a: assert property (run && k_do && !exit_code && code != LSQ_CMD_THEN // [R01]
      |=> cmd.valid && cmd.code == $past(code)) else $error("do command not dispatched");
   nest_limit_a: assert property (level_r <= 4'(LSQ_NEST_MAX)) // [R17]
      else $error("nesting above limit");
   else_weight_a: assert property (else_ok |=> level_r == $past(level_r) + 4'h1) // [R18]
      else $error("else level not counted");
   zero_delay_a: assert property (loop_jump |=> act.valid && act.kind == A_JUMP && !wait_r) // [R05]
      else $error("zero delay loop did not repeat");
   delay_resume_a: assert property (dly_done |=> act.valid && act.kind == A_JUMP && !wait_r) // [R06]
      else $error("delayed pass not resumed");
   wait_hold_a: assert property (loop_wait ##1 (wait_r && !exec_tick) |=> wait_r) // [R08]
      else $error("wait left without tick");
   restart_inh_a: assert property (dly_any |=> restart_inhibit && overrun_hide) // [R09]
      else $error("restart not inhibited");
   t2_block_a: assert property (dly_any && cur_table == 2'h1 |=> table2_block) // [R11]
      else $error("table two not blocked");
   flag_hold_a: assert property (out_flag && dly_any && table_start && !flag_clr |=> out_flag) // [R10]
      else $error("output flag cleared in delay loop");
   index_loc_a: assert property (live && instr.indexed && has_lp // [R13]
      |=> loc_eff == $past(instr.loc) + $past(idx_add)) else $error("indexed location wrong");
   entry_zero_a: assert property (do_push && k_loop // [R21]
      |=> iter_s[$past(sp_r)] == 16'h0000 && idx_s[$past(sp_r)] == 16'h0000)
      else $error("loop counter not cleared on entry");
   avg_zero_a: assert property (avg_hit && out_flag |=> acc_c[$past(instr.slot)] == 16'h0000) // [R15]
      else $error("storage not zeroed");

   // Pass control after a loop end, what the table sees while skipping or parked, and the scheduling status outputs.
   // Each looks one cycle later, when the registered outputs and state stand.
   exit_skip_a: assert property (skip_r && live && !is_end // [R02]
      |=> act.valid && act.kind == A_SKIP) else $error("skipped instruction not marked");
   count_stop_a: assert property (loop_end && !more && dly_s[top] == 16'h0000 // [R02]
      |=> act.valid && act.kind == A_NEXT) else $error("counted loop did not stop");
   unlimited_a: assert property (loop_end && cnt_s[top] == 16'h0000 && dly_s[top] == 16'h0000 // [R03]
      |=> act.valid && act.kind == A_JUMP) else $error("unlimited loop stopped");
   wait_ignore_a: assert property (wait_r && !dly_done |=> !act.valid) // [R07]
      else $error("instruction taken while parked");
   preempt_hold_a: assert property (cur_table == 2'h2 && out_flag |=> !table1_preempt_ok) // [R12]
      else $error("table one may preempt an output array");
   nest_block_a: assert property (push_err |=> nest_err && level_r == $past(level_r)) // [R17]
      else $error("refused opening changed the level");
   auto_clear_a: assert property (table_start && !dly_any && !flag_set |=> !out_flag) // [R10]
      else $error("output flag not cleared at table start");

   exit_cov: cover property (is_exit ##[1:20] skip_done);
   delay_cov: cover property (loop_wait ##[1:50] dly_done);
   nest_cov: cover property (push_err);
   avg_cov: cover property (avg_out.valid);
   jump_cov: cover property (loop_jump ##[1:10] pop);

endmodule

// ==== dv/lsq_top_tb.sv ====
// Self-checking testbench for the loop sequencer.
module lsq_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lsq_pkg::*;

`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
   $display("unexpected %s expected %0h seen %0h", nm, ex, gt); num_errors++; end end

   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   lsq_instr_t instr = '0;
   logic exec_tick = 1'b0;
   logic table_start = 1'b0;
   logic [1:0] cur_table = 2'h1;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   lsq_act_t act;
   lsq_cmd_t cmd;
   logic [11:0] loc_eff;
   lsq_avg_t avg_out;
   logic out_flag, restart_inhibit, overrun_hide, table2_block, table1_preempt_ok, nest_err;
   int num_errors = 0;
   int cmp_count = 0;
   lsq_instr_t ins;

   always #5 clk = ~clk;

   lsq_top uut (.clk(clk), .rst_n(rst_n), .instr(instr), .exec_tick(exec_tick), .table_start(table_start),
      .cur_table(cur_table), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .act(act), .cmd(cmd), .loc_eff(loc_eff), .avg_out(avg_out), .out_flag(out_flag),
      .restart_inhibit(restart_inhibit), .overrun_hide(overrun_hide), .table2_block(table2_block),
      .table1_preempt_ok(table1_preempt_ok), .nest_err(nest_err));

   // ----------------------------------------
   // Ordinary instruction cases
   // ----------------------------------------
   typedef struct {
      lsq_kind_t k; logic [11:0] pc; logic [15:0] p1; logic [15:0] p2; logic [11:0] loc; logic ix;
      lsq_act_kind_t ak; logic [11:0] apc; logic cv; logic [7:0] code; logic [11:0] le;
   } lsq_row_t;

   // The outer loop has index 1 when the inner loop opens, so an indexed location must show 8, not 9.
   lsq_row_t rows [14] = '{
      '{K_DO, 12'h001, 16'h000A, 16'h0000, 12'h000, 1'b0, A_NEXT, 12'h000, 1'b1, 8'h0A, 12'h000},
      '{K_DO, 12'h002, 16'h0014, 16'h0000, 12'h000, 1'b0, A_NEXT, 12'h000, 1'b1, 8'h14, 12'h000},
      '{K_LOOP, 12'h010, 16'h0000, 16'h0002, 12'h000, 1'b0, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h000},
      '{K_OTHER, 12'h011, 16'h0000, 16'h0000, 12'h005, 1'b1, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h005},
      '{K_OTHER, 12'h011, 16'h0000, 16'h0000, 12'h007, 1'b0, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h007},
      '{K_END, 12'h012, 16'h0000, 16'h0000, 12'h000, 1'b0, A_JUMP, 12'h011, 1'b0, 8'h00, 12'h000},
      '{K_OTHER, 12'h011, 16'h0000, 16'h0000, 12'h005, 1'b1, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h006},
      '{K_END, 12'h012, 16'h0000, 16'h0000, 12'h000, 1'b0, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h000},
      '{K_LOOP, 12'h040, 16'h0000, 16'h0002, 12'h000, 1'b0, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h000},
      '{K_END, 12'h044, 16'h0000, 16'h0000, 12'h000, 1'b0, A_JUMP, 12'h041, 1'b0, 8'h00, 12'h000},
      '{K_LOOP, 12'h041, 16'h0000, 16'h0001, 12'h000, 1'b0, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h000},
      '{K_OTHER, 12'h042, 16'h0000, 16'h0000, 12'h008, 1'b1, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h008},
      '{K_END, 12'h043, 16'h0000, 16'h0000, 12'h000, 1'b0, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h000},
      '{K_END, 12'h044, 16'h0000, 16'h0000, 12'h000, 1'b0, A_NEXT, 12'h000, 1'b0, 8'h00, 12'h000}
   };

   function automatic lsq_instr_t mk(lsq_kind_t k, logic [11:0] pc, logic [15:0] p1, logic [15:0] p2,
                                     logic [11:0] loc, logic ix);
      lsq_instr_t i;
      i = '0;
      i.valid = 1'b1;
      i.kind = k;
      i.pc = pc;
      i.p1 = p1;
      i.p2 = p2;
      i.loc = loc;
      i.indexed = ix;
      return i;
   endfunction

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic send(input lsq_instr_t i);
      @(posedge clk);
      instr <= i;
      @(posedge clk);
      instr <= '0;
      #1;
   endtask

   task automatic tick();
      @(posedge clk);
      exec_tick <= 1'b1;
      @(posedge clk);
      exec_tick <= 1'b0;
      #1;
   endtask

   // Status outputs register their inputs, so they need one more edge to show an effect.
   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic reg_check(input logic [1:0] a, input logic [15:0] ex);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", ex, reg_rdata)
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      `CHK("act.valid", 1'b0, act.valid)
      `CHK("cmd.valid", 1'b0, cmd.valid)
      `CHK("out_flag", 1'b0, out_flag)
      `CHK("table2_block", 1'b0, table2_block)
      `CHK("table1_preempt_ok", 1'b1, table1_preempt_ok)
      `CHK("nest_err", 1'b0, nest_err)
      rst_n <= 1'b1;
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      do_reset();
      reg_check(LSQ_REG_CTRL, 16'h0001);
      reg_check(2'h3, 16'h0000);
      reg_write(LSQ_REG_CTRL, 16'h0000);
      settle();
      `CHK("table2_block", 1'b1, table2_block)
      reg_write(2'h3, 16'h0001);
      reg_check(LSQ_REG_CTRL, 16'h0000);
      reg_write(LSQ_REG_CTRL, 16'h0001);
      foreach (rows[n]) begin
         send(mk(rows[n].k, rows[n].pc, rows[n].p1, rows[n].p2, rows[n].loc, rows[n].ix));
         `CHK("act.kind", rows[n].ak, act.kind)
         if (rows[n].ak == A_JUMP) `CHK("act.pc", rows[n].apc, act.pc)
         `CHK("cmd.valid", rows[n].cv, cmd.valid)
         if (rows[n].cv) `CHK("cmd.code", rows[n].code, cmd.code)
         `CHK("loc_eff", rows[n].le, loc_eff)
      end
      // Unlimited loop left by either exit command.
      for (int e = 0; e < 2; e++) begin
         send(mk(K_LOOP, 12'h050, 16'h0000, 16'h0000, 12'h000, 1'b0));
         repeat (2) begin
            send(mk(K_END, 12'h053, 16'h0000, 16'h0000, 12'h000, 1'b0));
            `CHK("act.kind", A_JUMP, act.kind)
         end
         ins = mk(K_CMD, 12'h051, (e == 0) ? {8'h00, LSQ_CMD_EXIT_T} : {8'h00, LSQ_CMD_EXIT_F}, 16'h0000,
                  12'h000, 1'b0);
         ins.cond_true = (e == 0);
         send(ins);
         send(mk(K_OTHER, 12'h052, 16'h0000, 16'h0000, 12'h000, 1'b0));
         `CHK("act.kind", A_SKIP, act.kind)
         send(mk(K_END, 12'h053, 16'h0000, 16'h0000, 12'h000, 1'b0));
         `CHK("act.kind", A_NEXT, act.kind)
      end
      reg_check(LSQ_REG_INDEX, 16'h0000);
      // Delayed loop, delay 2 and count 2, flag set beforehand.
      send(mk(K_DO, 12'h01F, 16'h000A, 16'h0000, 12'h000, 1'b0));
      send(mk(K_LOOP, 12'h020, 16'h0002, 16'h0002, 12'h000, 1'b0));
      settle();
      `CHK("restart_inhibit", 1'b1, restart_inhibit)
      `CHK("overrun_hide", 1'b1, overrun_hide)
      `CHK("table2_block", 1'b1, table2_block)
      for (int p = 0; p < 2; p++) begin
         send(mk(K_OTHER, 12'h021, 16'h0000, 16'h0000, 12'h000, 1'b0));
         send(mk(K_END, 12'h022, 16'h0000, 16'h0000, 12'h000, 1'b0));
         `CHK("act.kind", A_WAIT, act.kind)
         @(posedge clk);
         table_start <= 1'b1;
         @(posedge clk);
         table_start <= 1'b0;
         #1;
         `CHK("out_flag", 1'b1, out_flag)
         send(mk(K_OTHER, 12'h030, 16'h0000, 16'h0000, 12'h000, 1'b0));
         `CHK("act.valid", 1'b0, act.valid)
         tick();
         `CHK("act.valid", 1'b0, act.valid)
         tick();
         `CHK("act.valid", 1'b1, act.valid)
         `CHK("act.kind", A_JUMP, act.kind)
         `CHK("act.pc", (p == 0) ? 12'h021 : 12'h023, act.pc)
      end
      settle();
      `CHK("restart_inhibit", 1'b0, restart_inhibit)
      `CHK("table2_block", 1'b0, table2_block)
      @(posedge clk);
      table_start <= 1'b1;
      @(posedge clk);
      table_start <= 1'b0;
      #1;
      `CHK("out_flag", 1'b0, out_flag)
      // Table two mid output array holds off table one.
      cur_table <= 2'h2;
      send(mk(K_DO, 12'h003, 16'h000A, 16'h0000, 12'h000, 1'b0));
      settle();
      `CHK("table1_preempt_ok", 1'b0, table1_preempt_ok)
      send(mk(K_DO, 12'h004, 16'h0014, 16'h0000, 12'h000, 1'b0));
      settle();
      `CHK("table1_preempt_ok", 1'b1, table1_preempt_ok)
      cur_table <= 2'h1;
      // Average shares one count and total, zeroed at each output.
      for (int a = 0; a < 3; a++) begin
         if (a == 1) send(mk(K_DO, 12'h005, 16'h000A, 16'h0000, 12'h000, 1'b0));
         ins = mk(K_AVG, 12'h006, 16'h0000, 16'h0000, 12'h000, 1'b0);
         ins.slot = 4'h3;
         ins.sample = (a == 0) ? 32'h5 : ((a == 1) ? 32'h7 : 32'h4);
         send(ins);
         `CHK("avg_out.valid", (a != 0), avg_out.valid)
         if (a == 1) `CHK("avg_out.count", 16'h0002, avg_out.count)
         if (a == 1) `CHK("avg_out.total", 32'h0000000C, avg_out.total)
         if (a == 2) `CHK("avg_out.count", 16'h0001, avg_out.count)
         if (a == 2) `CHK("avg_out.total", 32'h00000004, avg_out.total)
      end
      // Seven loops, a then and an else fill all nine levels.
      repeat (7) send(mk(K_LOOP, 12'h070, 16'h0000, 16'h0001, 12'h000, 1'b0));
      ins = mk(K_CMD, 12'h071, {8'h00, LSQ_CMD_THEN}, 16'h0000, 12'h000, 1'b0);
      ins.cond_true = 1'b1;
      send(ins);
      send(mk(K_ELSE, 12'h072, 16'h0000, 16'h0000, 12'h000, 1'b0));
      `CHK("nest_err", 1'b0, nest_err)
      reg_check(LSQ_REG_STATUS, 16'h0029);
      send(mk(K_LOOP, 12'h073, 16'h0000, 16'h0001, 12'h000, 1'b0));
      `CHK("nest_err", 1'b1, nest_err)
      reg_write(LSQ_REG_CTRL, 16'h0003);
      `CHK("nest_err", 1'b0, nest_err)
      do_reset();
      reg_check(LSQ_REG_STATUS, 16'h0000);
      report_and_stop();
   end
endmodule
